/* File: psrs_pkg.sv */
package psrs_pkg;

////////////////////////////////////////////////////////////////////////////////
// timing
localparam int CLK_HZ        = 20_000_000;
localparam int CLK_PERIOD_NS = 50;
localparam int OSC_HZ        = 2_000_000;
localparam int OSC_DIV       = CLK_HZ / OSC_HZ;
localparam int SLOW_DIV      = 64;
localparam int SLOW_TICK_CYC = OSC_DIV * SLOW_DIV;
localparam int RST_SLOW_PER  = 256;
localparam int SLOW_VALID_NS = 10000;
// least time, so round up to whole cycles
localparam logic [7:0] SLOW_VALID_CYC = 8'((SLOW_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

////////////////////////////////////////////////////////////////////////////////
// register map, byte addresses
localparam int         ADDR_W       = 8;
localparam logic [7:0] REG_CMD      = 8'h00;
localparam logic [7:0] REG_CFG      = 8'h04;
localparam logic [7:0] REG_STATE    = 8'h08;
localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
localparam logic [7:0] REG_IRQ_CLR  = 8'h10;
localparam logic [7:0] REG_IRQ_EN   = 8'h14;
// command bits
localparam int CMD_GO_TX   = 0;
localparam int CMD_GO_RX   = 1;
localparam int CMD_GO_IDLE = 2;
// config bits and reset
localparam int   CFG_RETAIN     = 0;
localparam logic CFG_RETAIN_RST = 1'b1;
// state register fields
localparam int ST_CODE_LSB   = 0;
localparam int ST_SLOW_VALID = 3;
localparam int ST_SYS_RST_N  = 4;
localparam int ST_PERMIT     = 5;
localparam int ST_PWR_REQ    = 6;
localparam int ST_WAKE_N     = 7;
// interrupt bits
localparam int         IRQ_W         = 4;
localparam int         IRQ_SLEEP_IN  = 0;
localparam int         IRQ_SLEEP_OUT = 1;
localparam int         IRQ_RST_DONE  = 2;
localparam int         IRQ_RESTART   = 3;
localparam logic [3:0] IRQ_EN_RST    = 4'h0;
localparam logic       HOST_WAKE_RST = 1'b1;
// bus answers
localparam logic [1:0] RESP_OKAY   = 2'h0;
localparam logic [1:0] RESP_SLVERR = 2'h2;

////////////////////////////////////////////////////////////////////////////////
// device states
typedef enum logic [2:0] {
	PS_OFF, PS_OSC_WAIT, PS_BOOT, PS_ACTIVE, PS_RADIO_TX, PS_RADIO_RX, PS_SLEEP
} psrs_state_e;

endpackage

/* File: psrs_rst_if.sv */
`timescale 1ns/1ps
// links the sequencer to its reset counter
interface psrs_rst_if;
	logic slow_run;  // slow clock valid, divider may run
	logic por_det;   // power-on detector level
	logic brown_det; // brownout detector level
	logic sys_rst_n; // stretched system reset
	logic restart;   // pulse: detector hit a released reset
	modport seq (output slow_run, por_det, brown_det, input sys_rst_n, restart);
	modport ctr (input slow_run, por_det, brown_det, output sys_rst_n, restart);
endinterface // psrs_rst_if

/* File: psrs_reset_ctr.sv */
`timescale 1ns/1ps
module psrs_reset_ctr
	import psrs_pkg::*;
#(
	parameter int unsigned SLOW_TICK_CYCLES = SLOW_TICK_CYC,
	parameter int unsigned RESET_PERIODS    = RST_SLOW_PER
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// sequencer side
	psrs_rst_if.ctr  rif
);

	typedef struct packed {
		logic [9:0] div;     // cycles within one slow period
		logic [8:0] periods; // slow periods counted
		logic       rst_n;   // system reset, low = held
		logic       restart; // one-cycle event
	} psrs_ctr_s;

	psrs_ctr_s q;
	psrs_ctr_s d;

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		logic tick;
		tick = 1'b0;
		d = q;
		d.restart = 1'b0;
		if (!rif.slow_run) begin
			// no slow clock yet: hold everything in reset
			d.div = 10'h000;
			d.periods = 9'h000;
			d.rst_n = 1'b0;
		end else begin
			if (q.div == 10'(SLOW_TICK_CYCLES - 1)) begin
				d.div = 10'h000;
				tick = 1'b1;
			end else begin
				d.div = q.div + 10'h001;
			end
			if (rif.por_det || rif.brown_det) begin
				d.div = 10'h000;
				d.periods = 9'h000;
				d.rst_n = 1'b0;
				d.restart = q.rst_n;
			end else if (!q.rst_n && tick) begin
				if (q.periods == 9'(RESET_PERIODS - 1)) begin
					d.rst_n = 1'b1;
				end else begin
					d.periods = q.periods + 9'h001;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign rif.sys_rst_n = q.rst_n;
	assign rif.restart = q.restart;

endmodule // psrs_reset_ctr

/* File: psrs_top.sv */
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module psrs_top
	import psrs_pkg::*;
#(
	// shorten these two to speed up simulation
	parameter int unsigned SLOW_TICK_CYCLES = SLOW_TICK_CYC,
	parameter int unsigned RESET_PERIODS    = RST_SLOW_PER
) (
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// axi4-lite write
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output wire logic              s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output wire logic              s_axi_wready,
	output wire logic [1:0]        s_axi_bresp,
	output wire logic              s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// axi4-lite read
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output wire logic              s_axi_arready,
	output wire logic [31:0]       s_axi_rdata,
	output wire logic [1:0]        s_axi_rresp,
	output wire logic              s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// host pins
	input  wire logic              pwr_req_pin,
	input  wire logic              sleep_permit_pin,
	input  wire logic              io_supply,
	output wire logic              host_wake_n,
	// analogue detectors
	input  wire logic              por_det,
	input  wire logic              brownout_detector,
	// core events
	input  wire logic              radio_evt_pending,
	input  wire logic              host_evt_pending,
	// power and reset controls
	output wire logic              sys_rst_n,
	output wire logic              slow_clk_valid,
	output wire logic              ao_pwr_on,
	output wire logic              core_pwr_on,
	output wire logic              cpu_pwr_on,
	output wire logic              radio_pwr_on,
	output wire logic              ram_retain_on,
	output wire logic              radio_tx_state,
	output wire logic              radio_rx_state,
	// interrupt
	output wire logic              irq
);

	////////////////////////////////////////////////////////////////////////////
	// state
	typedef struct packed {
		psrs_state_e       st;         // device state
		logic [7:0]        wait_cnt;   // oscillator settle count
		logic              req_prev;   // request pin last cycle
		logic              retain;     // keep ram in sleep
		logic [IRQ_W-1:0]  irq_st;     // sticky events
		logic [IRQ_W-1:0]  irq_en;     // event enables
		logic              aw_full;    // address held
		logic [ADDR_W-1:0] aw_addr;
		logic              w_full;     // data held
		logic [31:0]       w_data;
		logic [3:0]        w_strb;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		logic [6:0]        pwr;        // decoded power outputs
		logic              slow_valid;
		logic              wake_n;
		logic              irq;
	} psrs_top_s;

	psrs_top_s q;
	psrs_top_s d;

	psrs_rst_if rif ();

	////////////////////////////////////////////////////////////////////////////
	// power outputs per state: ao, core, cpu, radio, ram, tx, rx
	function automatic logic [6:0] pwr_map(psrs_state_e s, logic keep_ram);
		logic [6:0] p;
		p = 7'h00;
		case (s)
			PS_OFF: begin
				// core supply removed entirely
				p = 7'h00;
			end
			PS_OSC_WAIT: begin
				p = 7'h40;
			end
			PS_BOOT, PS_ACTIVE: begin
				p = 7'h70;
			end
			PS_RADIO_TX: begin
				p = 7'h7A;
			end
			PS_RADIO_RX: begin
				p = 7'h79;
			end
			PS_SLEEP: begin
				p = {1'b1, 3'b000, keep_ram, 2'b00};
			end
			default: begin
				p = 7'h00;
			end
		endcase
		return p;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		logic             do_wr;
		logic [2:0]       cmd;
		logic [IRQ_W-1:0] clr;
		logic [IRQ_W-1:0] ev;
		logic             rise;
		do_wr = 1'b0;
		cmd = 3'b000;
		clr = '0;
		ev = '0;
		rise = 1'b0;
		d = q;

		// write channels taken in either order
		if (s_axi_awvalid && q.awready) begin
			d.aw_full = 1'b1;
			d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && q.wready) begin
			d.w_full = 1'b1;
			d.w_data = s_axi_wdata;
			d.w_strb = s_axi_wstrb;
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		do_wr = q.aw_full && q.w_full && !q.bvalid;
		if (do_wr) begin
			d.aw_full = 1'b0;
			d.w_full = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = RESP_OKAY;
			case (q.aw_addr)
				REG_CMD: begin
					if (q.w_strb[0]) begin
						cmd = q.w_data[2:0];
					end
				end
				REG_CFG: begin
					if (q.w_strb[0]) begin
						d.retain = q.w_data[CFG_RETAIN];
					end
				end
				REG_IRQ_CLR: begin
					if (q.w_strb[0]) begin
						clr = q.w_data[IRQ_W-1:0];
					end
				end
				REG_IRQ_EN: begin
					if (q.w_strb[0]) begin
						d.irq_en = q.w_data[IRQ_W-1:0];
					end
				end
				// state and status are read only
				REG_STATE, REG_IRQ_STAT: begin
					d.bresp = RESP_OKAY;
				end
				default: begin
					d.bresp = RESP_SLVERR;
				end
			endcase
		end
		// one write at a time: stall both channels while answering
		d.awready = !d.aw_full && !d.bvalid;
		d.wready = !d.w_full && !d.bvalid;

		// read: answer the cycle after the address is taken
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && q.arready) begin
			d.rvalid = 1'b1;
			d.rresp = RESP_OKAY;
			d.rdata = 32'h0000_0000;
			case (s_axi_araddr)
				REG_CFG: begin
					d.rdata[CFG_RETAIN] = q.retain;
				end
				REG_STATE: begin
					d.rdata[ST_CODE_LSB +: 3] = q.st;
					d.rdata[ST_SLOW_VALID] = q.slow_valid;
					d.rdata[ST_SYS_RST_N] = rif.sys_rst_n;
					d.rdata[ST_PERMIT] = sleep_permit_pin;
					d.rdata[ST_PWR_REQ] = pwr_req_pin;
					d.rdata[ST_WAKE_N] = q.wake_n;
				end
				REG_IRQ_STAT: begin
					d.rdata[IRQ_W-1:0] = q.irq_st;
				end
				REG_IRQ_EN: begin
					d.rdata[IRQ_W-1:0] = q.irq_en;
				end
				// command and clear read as zero
				REG_CMD, REG_IRQ_CLR: begin
					d.rresp = RESP_OKAY;
				end
				default: begin
					d.rresp = RESP_SLVERR;
				end
			endcase
		end
		d.arready = !d.rvalid;

		// request pin edge, only with io supply up
		d.req_prev = pwr_req_pin;
		rise = pwr_req_pin && !q.req_prev && io_supply;

		case (q.st)
			PS_OFF: begin
				// leave off on rising request only
				if (rise) begin
					d.st = PS_OSC_WAIT;
					d.wait_cnt = 8'h00;
				end
			end
			PS_OSC_WAIT: begin
				if (q.wait_cnt == SLOW_VALID_CYC - 8'h01) begin
					d.st = PS_BOOT;
				end else begin
					d.wait_cnt = q.wait_cnt + 8'h01;
				end
			end
			PS_BOOT: begin
				if (rif.sys_rst_n) begin
					d.st = PS_ACTIVE;
					ev[IRQ_RST_DONE] = 1'b1;
				end
			end
			PS_ACTIVE: begin
				if (cmd[CMD_GO_TX]) begin
					d.st = PS_RADIO_TX;
				end else if (cmd[CMD_GO_RX]) begin
					d.st = PS_RADIO_RX;
				// sleep only with permit low, idle radio
				end else if (!sleep_permit_pin && !radio_evt_pending) begin
					d.st = PS_SLEEP;
					ev[IRQ_SLEEP_IN] = 1'b1;
				end
			end
			PS_RADIO_TX, PS_RADIO_RX: begin
				// radio states end by command, or by system reset or request low below
				if (cmd[CMD_GO_IDLE]) begin
					d.st = PS_ACTIVE;
				end else if (cmd[CMD_GO_TX]) begin
					d.st = PS_RADIO_TX;
				end else if (cmd[CMD_GO_RX]) begin
					d.st = PS_RADIO_RX;
				end
			end
			PS_SLEEP: begin
				// wake on permit, radio events too
				if (sleep_permit_pin || radio_evt_pending) begin
					d.st = PS_ACTIVE;
					ev[IRQ_SLEEP_OUT] = 1'b1;
				end
			end
			default: begin
				d.st = PS_OFF;
			end
		endcase
		if (!rif.sys_rst_n && q.st != PS_OFF && q.st != PS_OSC_WAIT) begin
			d.st = PS_BOOT;
		end
		// request low powers the core off
		if (!pwr_req_pin) begin
			d.st = PS_OFF;
		end
		ev[IRQ_RESTART] = rif.restart;

		// sticky status, a new event beats its clear
		d.irq_st = (q.irq_st & ~clr) | ev;
		d.irq = |(d.irq_st & d.irq_en);

		// outputs follow the next state so they leave a flop
		d.pwr = pwr_map(d.st, d.retain);
		d.slow_valid = d.st != PS_OFF && d.st != PS_OSC_WAIT;
		// host wake low while data waits
		d.wake_n = !(host_evt_pending && d.st != PS_OFF);
	end

	////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.st <= PS_OFF;
			// high so a pin already high is no edge
			q.req_prev <= 1'b1;
			q.retain <= CFG_RETAIN_RST;
			q.irq_en <= IRQ_EN_RST;
			q.wake_n <= HOST_WAKE_RST;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// reset counter on the slow clock
	assign rif.slow_run = q.slow_valid;
	assign rif.por_det = por_det;
	assign rif.brown_det = brownout_detector;

	psrs_reset_ctr #(
		.SLOW_TICK_CYCLES (SLOW_TICK_CYCLES),
		.RESET_PERIODS    (RESET_PERIODS)
	) u_reset_ctr (
		.aclk    (aclk),
		.aresetn (aresetn),
		.rif     (rif.ctr)
	);

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.wready;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign host_wake_n = q.wake_n;
	assign sys_rst_n = rif.sys_rst_n;
	assign slow_clk_valid = q.slow_valid;
	assign ao_pwr_on = q.pwr[6];
	assign core_pwr_on = q.pwr[5];
	assign cpu_pwr_on = q.pwr[4];
	assign radio_pwr_on = q.pwr[3];
	assign ram_retain_on = q.pwr[2];
	assign radio_tx_state = q.pwr[1];
	assign radio_rx_state = q.pwr[0];
	assign irq = q.irq;

endmodule // psrs_top

/* File: psrs_properties.sv */
`timescale 1ns/1ps
module psrs_properties
	import psrs_pkg::*;
#(
	parameter int unsigned SLOW_TICK_CYCLES = SLOW_TICK_CYC,
	parameter int unsigned RESET_PERIODS    = RST_SLOW_PER
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// host pins
	input wire logic pwr_req_pin,
	input wire logic sleep_permit_pin,
	input wire logic io_supply,
	input wire logic host_wake_n,
	// detectors and events
	input wire logic por_det,
	input wire logic brownout_detector,
	input wire logic radio_evt_pending,
	input wire logic host_evt_pending,
	// power controls
	input wire logic sys_rst_n,
	input wire logic slow_clk_valid,
	input wire logic ao_pwr_on,
	input wire logic core_pwr_on,
	input wire logic cpu_pwr_on,
	input wire logic radio_pwr_on,
	input wire logic radio_tx_state,
	input wire logic radio_rx_state
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////////////////
	logic [15:0] osc_q;  // cycles spent waiting for the slow clock
	logic [31:0] hold_q; // slow-valid cycles with both detectors quiet
	// wait counters, cleared whenever their condition breaks
	always_ff @(posedge aclk) begin
		if (!aresetn || !ao_pwr_on || slow_clk_valid)
			osc_q <= 16'h0;
		else
			osc_q <= osc_q + 16'h1;
		// a detector hit must restart the whole hold
		if (!aresetn || !slow_clk_valid || por_det || brownout_detector)
			hold_q <= 32'h0;
		else
			hold_q <= hold_q + 32'h1;
	end
	////////////////////////////////////////////////////////////////////////////////
	AST_RADIO_CPU: assert property (radio_pwr_on |-> cpu_pwr_on && core_pwr_on)
		else $error("radio powered without processor");
	AST_RADIO_MODES: assert property (radio_tx_state || radio_rx_state |-> radio_pwr_on
		&& !(radio_tx_state && radio_rx_state))
		else $error("radio mode outputs inconsistent");
	AST_SLEEP_DOMAINS: assert property (ao_pwr_on && !core_pwr_on |-> !cpu_pwr_on && !radio_pwr_on)
		else $error("switchable domain powered without core");
	AST_OFF_EXIT: assert property ($rose(ao_pwr_on) |-> $past(pwr_req_pin) && !$past(pwr_req_pin, 2)
		&& $past(io_supply))
		else $error("left off state without request edge");
	AST_PERMIT_HOLD: assert property (sleep_permit_pin && core_pwr_on |=> core_pwr_on || !ao_pwr_on)
		else $error("sleep entered while permitted high");
	AST_SLEEP_ENTRY: assert property (core_pwr_on && !radio_pwr_on && sys_rst_n && $past(sys_rst_n) && pwr_req_pin
		&& !sleep_permit_pin && !radio_evt_pending |=> ao_pwr_on && !core_pwr_on)
		else $error("idle device did not enter sleep");
	AST_SLEEP_EXIT: assert property (ao_pwr_on && !core_pwr_on && slow_clk_valid && sys_rst_n && pwr_req_pin
		&& sleep_permit_pin |=> core_pwr_on)
		else $error("no wake from sleep on permit");
	AST_SLOW_WAIT: assert property ($rose(slow_clk_valid) |-> osc_q >= SLOW_VALID_CYC)
		else $error("slow clock valid too early");
	AST_RESET_HOLD: assert property ($rose(sys_rst_n) |-> hold_q >= SLOW_TICK_CYCLES * RESET_PERIODS)
		else $error("system reset released too early");
	AST_DET_RESTART: assert property (por_det || brownout_detector |-> ##[1:3] !sys_rst_n)
		else $error("detector did not assert system reset");
	AST_WAKE_LOW: assert property (host_evt_pending && ao_pwr_on && pwr_req_pin |=> !host_wake_n)
		else $error("host wake not low with data pending");
	AST_WAKE_HIGH: assert property (!host_evt_pending |=> host_wake_n)
		else $error("host wake low with nothing pending");
	// main scenarios reached
	COV_RELEASE: cover property ($rose(sys_rst_n));
	COV_SLEEP: cover property ($fell(core_pwr_on) && ao_pwr_on);
	COV_TX: cover property ($rose(radio_tx_state));
endmodule // psrs_properties

bind psrs_top psrs_properties #(
	.SLOW_TICK_CYCLES(SLOW_TICK_CYCLES),
	.RESET_PERIODS   (RESET_PERIODS)
) psrs_properties_inst (.*);

/* File: psrs_host_model.sv */
`timescale 1ns/1ps
// host side: orders io supply, request and sleep permit
module psrs_host_model (
	// clock
	input  wire logic aclk,
	// bench wishes
	input  wire logic want_io,
	input  wire logic want_on,
	input  wire logic want_permit,
	// pins toward the device
	output var  logic io_supply,
	output var  logic pwr_req_pin,
	output var  logic sleep_permit_pin
);
	// pins always driven, request low at start
	initial begin
		io_supply        = 1'b0;
		pwr_req_pin      = 1'b0;
		sleep_permit_pin = 1'b1;
	end
	always @(posedge aclk) begin
		pwr_req_pin      <= want_on && io_supply;
		io_supply        <= want_io || pwr_req_pin;
		sleep_permit_pin <= want_permit;
	end
endmodule // psrs_host_model

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top
	import psrs_pkg::*;
;
	// bus
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	// pins, events, power
	logic        pwr_req_pin, sleep_permit_pin, io_supply, host_wake_n, por_det, brownout_detector, irq;
	logic        radio_evt_pending, host_evt_pending, sys_rst_n, slow_clk_valid, ao_pwr_on, core_pwr_on;
	logic        cpu_pwr_on, radio_pwr_on, ram_retain_on, radio_tx_state, radio_rx_state, want_io, want_on, want_permit;
	int          err_total, comparisons;
	// short reset hold: 4 cycles a tick, 3 ticks
	psrs_top #(.SLOW_TICK_CYCLES(4), .RESET_PERIODS(3)) psrs_top_inst (.*);
	psrs_host_model psrs_host_model_inst (.*);
	always #(CLK_PERIOD_NS / 2) aclk = ~aclk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// compare and count
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// bus write, bready held until the answer; a hang is left to the watchdog
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		resp = s_axi_bresp;
	endtask
	// bus read into rd
	task automatic axr(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		rd = s_axi_rdata;
		resp = s_axi_rresp;
	endtask
	// verdict, reached from the tests or the watchdog
	task automatic summarize;
		$display("comparisons=%0d err_total=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// watchdog, well past the expected few hundred cycles
	initial begin
		#(CLK_PERIOD_NS * 20000);
		err_total++;
		summarize();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
		{por_det, brownout_detector, radio_evt_pending, host_evt_pending, want_io, want_on} = 6'h0;
		want_permit = 1'b1;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		wt(2);
		chk({host_wake_n, ao_pwr_on, sys_rst_n, irq}, 4'h8);
		axr(REG_CFG);
		chk(rd, 32'h1);
		axr(8'hFC);
		chk(resp, RESP_SLVERR);
		chk(rd, 32'h0);
		axw(8'hF0, 32'h0);
		chk(resp, RESP_SLVERR);
		$display("reset test done");
		// power-up: off only left on a request edge
		want_io <= 1'b1;
		wt(3);
		chk(ao_pwr_on, 1'b0);
		want_on <= 1'b1;
		wt(4);
		axr(REG_STATE);
		chk({rd[2:0], slow_clk_valid, sys_rst_n}, 5'h4);
		axw(REG_IRQ_EN, 32'hF);
		wt(210);
		chk({slow_clk_valid, sys_rst_n, core_pwr_on, irq}, 4'hF);
		axr(REG_STATE);
		chk(rd[2:0], 32'h3);
		axw(REG_IRQ_CLR, 32'hF);
		wt(2);
		chk(irq, 1'b0);
		$display("power-up test done");
		// software steers the radio modes
		for (int i = 0; i < 3; i++) begin
			axw(REG_CMD, 32'h1 << i);
			wt(2);
			chk({radio_tx_state, radio_rx_state, radio_pwr_on, cpu_pwr_on}, {i == 0, i == 1, i < 2, 1'b1});
		end
		$display("radio test done");
		// sleep with and without retention
		for (int k = 1; k >= 0; k--) begin
			axw(REG_CFG, 32'(k));
			radio_evt_pending <= 1'b1;
			want_permit <= 1'b0;
			wt(5);
			chk(core_pwr_on, 1'b1);
			radio_evt_pending <= 1'b0;
			wt(3);
			chk({ao_pwr_on, core_pwr_on, cpu_pwr_on, radio_pwr_on, ram_retain_on}, {4'h8, k[0]});
			want_permit <= 1'b1;
			wt(4);
			chk({core_pwr_on, cpu_pwr_on}, 2'h3);
		end
		// a pending radio event also ends sleep
		want_permit <= 1'b0;
		wt(4);
		chk(core_pwr_on, 1'b0);
		radio_evt_pending <= 1'b1;
		wt(2);
		chk(core_pwr_on, 1'b1);
		want_permit <= 1'b1;
		wt(2);
		radio_evt_pending <= 1'b0;
		axr(REG_IRQ_STAT);
		chk(rd[1:0], 32'h3);
		axw(REG_IRQ_CLR, 32'hF);
		$display("sleep test done");
		// host wake follows pending data
		host_evt_pending <= 1'b1;
		wt(6);
		chk(host_wake_n, 1'b0);
		host_evt_pending <= 1'b0;
		wt(3);
		chk(host_wake_n, 1'b1);
		$display("wake test done");
		// each detector restarts the reset hold
		for (int j = 0; j < 2; j++) begin
			por_det <= (j == 0);
			brownout_detector <= (j == 1);
			wt(10);
			chk({sys_rst_n, irq}, 2'h1);
			por_det <= 1'b0;
			brownout_detector <= 1'b0;
			wt(8);
			chk(sys_rst_n, 1'b0);
			wt(10);
			chk(sys_rst_n, 1'b1);
			axw(REG_IRQ_CLR, 32'hF);
		end
		$display("detector test done");
		// request low powers down
		want_on <= 1'b0;
		wt(3);
		chk({ao_pwr_on, core_pwr_on, host_wake_n}, 3'h1);
		$display("power-down test done");
		summarize();
	end
endmodule // tb_top
